//--- design/led_cfg_pkg.sv
// Constants, types and lookup functions shared by both ends of the LED
// driver configuration link. Assumes one 100 MHz clock on both ends.
//
// How it works
// (RL1) Current select 1 uses measured resistor code
// (RL2) Runtime write cannot set current select
// (RL3) Current-set resistor measured during start-up sequence
// (RL4) Current codes map 5..50 mA
// (RL5) Host clears select, writes current code
// (RL6) Current readback shows active current code
// (RL7) Measured current readable only if select loaded
// (RL8) Faulty current-set terminal forces 23 mA
// (RL9) Frequency select 1 uses measured terminal code
// (RL10) Runtime write cannot set frequency select
// (RL11) Frequency-set terminal is measured continuously
// (RL12) Frequency codes map 4.9..39.1 kHz
// (RL13) Host clears select, writes frequency code
// (RL14) Frequency readback shows active frequency code
// (RL15) Measured frequency readable only with select 1
// (RL16) Faulty frequency-set terminal forces 19.5 kHz
// (RL17) Threshold splits PWM and current dimming
// (RL18) Duty keeps full 12-bit precision always
// (RL19) Inductor size bit selects inductor range
// (RL20) Boost switch frequency fixed from nonvolatile
// (RL21) Reserved bits read zero, ignore writes; reserved boost register bits are stored and read back as written
package led_cfg_pkg;

    // Device register map
    localparam logic [7:0] CURRENT_ADDR  = 8'h11;
    localparam logic [7:0] PWM_ADDR      = 8'h12;
    localparam logic [7:0] BOOST_ADDR    = 8'h13;
    localparam int         SEL_BIT       = 7;
    localparam int         CODE_LSB      = 0;
    localparam int         CODE_MSB      = 2;
    localparam int         THR_LSB       = 3;
    localparam int         THR_MSB       = 5;
    localparam int         INDUCTOR_BIT  = 1;
    localparam int         BSW_FREQ_BIT  = 0;

    // Fallback codes for a grounded or floating set terminal
    localparam logic [2:0] CURR_FALLBACK = 3'h4;
    localparam logic [2:0] FREQ_FALLBACK = 3'h3;

    // Start-up resistor measurement window
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         MEAS_TIME_NS  = 2000;
    localparam int         MEAS_CYCLES   = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         MEAS_W        = $clog2(MEAS_CYCLES + 1);

    // Host controller register map
    localparam logic [2:0] H_TARGET      = 3'h0;
    localparam logic [2:0] H_WRITE       = 3'h1;
    localparam logic [2:0] H_READ        = 3'h2;
    localparam logic [2:0] H_RESULT      = 3'h3;
    localparam logic [2:0] H_STATUS      = 3'h4;

    // Dimming threshold boundaries on the 12-bit brightness scale
    localparam logic [11:0] THR_25_PCT   = 12'h400;
    localparam logic [11:0] THR_50_PCT   = 12'h800;
    localparam logic [2:0]  THR_ALL_CURR = 3'h0;
    localparam logic [2:0]  THR_25       = 3'h5;
    localparam logic [2:0]  THR_ALL_PWM  = 3'h7;

    typedef enum logic [1:0] {
        ST_LOAD    = 2'b00,
        ST_MEASURE = 2'b01,
        ST_RUN     = 2'b10
    } dev_state_t;

    // Full-scale current in mA
    function automatic logic [5:0] current_ma(input logic [2:0] code);
        unique case (code)
            3'h0: current_ma = 6'h05;
            3'h1: current_ma = 6'h0A;
            3'h2: current_ma = 6'h0F;
            3'h3: current_ma = 6'h14;
            3'h4: current_ma = 6'h17;
            3'h5: current_ma = 6'h19;
            3'h6: current_ma = 6'h1E;
            3'h7: current_ma = 6'h32;
        endcase
    endfunction

    // PWM output frequency in tenths of kHz; codes off the table fall to
    // the setting of their highest set bit
    function automatic logic [8:0] freq_dkhz(input logic [2:0] code);
        if (code[2]) begin
            freq_dkhz = 9'h187;
        end else if (code[1]) begin
            freq_dkhz = 9'h0C3;
        end else if (code[0]) begin
            freq_dkhz = 9'h062;
        end else begin
            freq_dkhz = 9'h031;
        end
    endfunction

endpackage

//--- design/led_cfg_link.sv
// Register link between the host controller and the LED driver.
// Both ends run on the same clock; read data stand one cycle after the read.
`timescale 1ns/1ns
`default_nettype none
interface led_cfg_link;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

//--- design/led_cfg_regs.sv
// Configuration register bank of the LED driver: current, PWM output and
// boost registers behind the register link.
// Assumes the nonvolatile image and terminal measurements are steady inputs.
`timescale 1ns/1ns
`default_nettype none
module led_cfg_regs #(
    // Cycles spent measuring the current-set resistor after the image loads
    parameter int MEAS_CYCLES = led_cfg_pkg::MEAS_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Register link
    led_cfg_link.device      link,
    // Nonvolatile defaults, loaded at start-up
    input  wire logic [7:0]  i_nv_current,
    input  wire logic [7:0]  i_nv_pwm,
    input  wire logic [7:0]  i_nv_boost,
    // Terminal measurements
    input  wire logic [2:0]  i_current_set_terminal_code,
    input  wire logic        i_current_set_terminal_fault,
    input  wire logic [2:0]  i_freq_set_pin_code,
    input  wire logic        i_freq_set_pin_fault,
    // Brightness from the core
    input  wire logic [11:0] i_brightness,
    // Settings in effect
    output logic             o_ready,
    output logic [2:0]       o_full_scale_current_code,
    output logic [5:0]       o_full_scale_current_ma,
    output logic [2:0]       o_pwm_out_freq_code,
    output logic [8:0]       o_pwm_out_freq_dkhz,
    output logic             o_pwm_dimming,
    output logic [11:0]      o_pwm_duty,
    output logic             o_inductor_size,
    output logic             o_boost_switch_freq
);

    // Wide enough to hold the last count without wrapping
    localparam int MEAS_W = $clog2(MEAS_CYCLES + 1);

    typedef struct packed {
        led_cfg_pkg::dev_state_t st;
        logic [MEAS_W-1:0] meas_cnt;
        logic        cur_sel;
        logic [2:0]  cur_code;
        logic [2:0]  cur_meas;
        logic        frq_sel;
        logic [2:0]  thr;
        logic [2:0]  frq_code;
        logic [2:0]  frq_meas;
        logic [7:0]  boost;
        logic        bsw_freq;
        logic [7:0]  rdata;
        logic [2:0]  cur_active;
        logic [5:0]  cur_ma;
        logic [2:0]  frq_active;
        logic [8:0]  frq_dkhz;
        logic        pwm_dim;
        logic [11:0] duty;
        logic        ready;
    } dev_t;

    dev_t s_q;
    dev_t s_d;

    logic [2:0]  cur_act;
    logic [2:0]  frq_act;
    logic [2:0]  frq_now;
    logic        below_thr;

    always_comb begin
        s_d = s_q;

        // Frequency terminal is sampled every cycle, whatever the select;
        // the fault is tested first so a floating pin never passes as a code
        frq_now = i_freq_set_pin_fault ? led_cfg_pkg::FREQ_FALLBACK   // [RL16]
                                       : i_freq_set_pin_code;
        s_d.frq_meas = frq_now;                                     // [RL11]

        unique case (s_q.st)
            led_cfg_pkg::ST_LOAD: begin
                // Image is taken once; a host write in this cycle lands on top of it
                s_d.cur_sel  = i_nv_current[led_cfg_pkg::SEL_BIT];
                s_d.cur_code = i_nv_current[led_cfg_pkg::CODE_MSB:led_cfg_pkg::CODE_LSB];
                s_d.frq_sel  = i_nv_pwm[led_cfg_pkg::SEL_BIT];
                s_d.thr      = i_nv_pwm[led_cfg_pkg::THR_MSB:led_cfg_pkg::THR_LSB];
                s_d.frq_code = i_nv_pwm[led_cfg_pkg::CODE_MSB:led_cfg_pkg::CODE_LSB];
                s_d.boost    = i_nv_boost;
                s_d.bsw_freq = i_nv_boost[led_cfg_pkg::BSW_FREQ_BIT];    // [RL20]
                s_d.meas_cnt = '0;
                s_d.st       = led_cfg_pkg::ST_MEASURE;
            end
            led_cfg_pkg::ST_MEASURE: begin
                // Resistor is read once, at the end of the window
                if (s_q.meas_cnt == MEAS_W'(MEAS_CYCLES - 1)) begin
                    s_d.cur_meas = i_current_set_terminal_fault
                                   ? led_cfg_pkg::CURR_FALLBACK          // [RL8]
                                   : i_current_set_terminal_code;       // [RL3]
                    s_d.ready    = 1'b1;
                    s_d.st       = led_cfg_pkg::ST_RUN;
                end else begin
                    s_d.meas_cnt = s_q.meas_cnt + 1'b1;
                end
            end
            led_cfg_pkg::ST_RUN: begin
                // Current terminal is no longer watched; a later fault goes unseen
                s_d.st = led_cfg_pkg::ST_RUN;
            end
            default: begin
                s_d.st = led_cfg_pkg::ST_LOAD;
            end
        endcase

        // Host writes; select bits can only be cleared at run time
        if (link.wr) begin
            unique case (link.addr)
                led_cfg_pkg::CURRENT_ADDR: begin
                    // A one written to the select cannot re-arm the measured source
                    s_d.cur_sel  = s_q.cur_sel & link.wdata[led_cfg_pkg::SEL_BIT];   // [RL2] [RL5]
                    s_d.cur_code = link.wdata[led_cfg_pkg::CODE_MSB:led_cfg_pkg::CODE_LSB];
                end
                led_cfg_pkg::PWM_ADDR: begin
                    s_d.frq_sel  = s_q.frq_sel & link.wdata[led_cfg_pkg::SEL_BIT];   // [RL10] [RL13]
                    s_d.thr      = link.wdata[led_cfg_pkg::THR_MSB:led_cfg_pkg::THR_LSB];
                    s_d.frq_code = link.wdata[led_cfg_pkg::CODE_MSB:led_cfg_pkg::CODE_LSB];
                end
                led_cfg_pkg::BOOST_ADDR: begin
                    // Stored and read back, but the switch frequency stays put
                    s_d.boost = link.wdata;                              // [RL20]
                end
                default: begin
                    // Writes to unmapped addresses are dropped
                    s_d.boost = s_d.boost;
                end
            endcase
        end

        // Settings in effect follow the registers just updated
        cur_act = s_d.cur_sel ? s_d.cur_meas : s_d.cur_code;         // [RL1]
        frq_act = s_d.frq_sel ? s_d.frq_meas : s_d.frq_code;         // [RL9]
        s_d.cur_active = cur_act;
        s_d.cur_ma     = led_cfg_pkg::current_ma(cur_act);           // [RL4]
        s_d.frq_active = frq_act;
        s_d.frq_dkhz   = led_cfg_pkg::freq_dkhz(frq_act);            // [RL12]

        // Other codes compare against the 50% point halved by (5 - code[1:0]);
        // the ladder is not monotonic in the code, so only named points are safe
        unique case (s_d.thr)
            led_cfg_pkg::THR_ALL_CURR: below_thr = 1'b0;
            led_cfg_pkg::THR_25:       below_thr = i_brightness < led_cfg_pkg::THR_25_PCT;
            led_cfg_pkg::THR_ALL_PWM:  below_thr = 1'b1;
            default:                   below_thr = i_brightness < led_cfg_pkg::THR_50_PCT
                                                   >> (3'h5 - s_d.thr[1:0]);
        endcase
        s_d.pwm_dim = below_thr;                                     // [RL17]
        s_d.duty    = i_brightness;                                  // [RL18]

        // Read data: active codes, current and PWM reserved bits zero; taken from the state
        // before this edge, which is safe as reads and writes never share a cycle
        s_d.rdata = 8'h00;
        if (link.rd) begin
            unique case (link.addr)
                led_cfg_pkg::CURRENT_ADDR: begin
                    s_d.rdata[led_cfg_pkg::SEL_BIT] = s_q.cur_sel;
                    s_d.rdata[led_cfg_pkg::CODE_MSB:led_cfg_pkg::CODE_LSB] =
                        s_q.cur_active;                              // [RL6] [RL7] [RL21]
                end
                led_cfg_pkg::PWM_ADDR: begin
                    s_d.rdata[led_cfg_pkg::SEL_BIT] = s_q.frq_sel;
                    s_d.rdata[led_cfg_pkg::THR_MSB:led_cfg_pkg::THR_LSB] = s_q.thr;
                    s_d.rdata[led_cfg_pkg::CODE_MSB:led_cfg_pkg::CODE_LSB] =
                        s_q.frq_active;                              // [RL14] [RL15] [RL21]
                end
                led_cfg_pkg::BOOST_ADDR: begin
                    // Reserved boost bits are plain storage and read back as written
                    s_d.rdata = s_q.boost;                           // [RL19]
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end
    end

    // All state in one register keeps reset and update in one place
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Every output comes straight from the state register
    assign link.rdata                = s_q.rdata;
    assign o_ready                   = s_q.ready;
    assign o_full_scale_current_code = s_q.cur_active;
    assign o_full_scale_current_ma   = s_q.cur_ma;
    assign o_pwm_out_freq_code       = s_q.frq_active;
    assign o_pwm_out_freq_dkhz       = s_q.frq_dkhz;
    assign o_pwm_dimming             = s_q.pwm_dim;
    assign o_pwm_duty                = s_q.duty;
    assign o_inductor_size           = s_q.boost[led_cfg_pkg::INDUCTOR_BIT];   // [RL19]
    assign o_boost_switch_freq       = s_q.bsw_freq;

endmodule
`default_nettype wire

//--- design/led_cfg_host.sv
// Host controller end: takes orders from software over a plain register
// port and issues single writes and reads on the register link.
// Assumes the device answers a read in the next cycle.
`timescale 1ns/1ns
`default_nettype none
module led_cfg_host (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Software port
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    // Register link
    led_cfg_link.host       link
);

    typedef struct packed {
        logic [7:0] target;
        logic [7:0] result;
        logic       done;
        logic       pending;
        logic [7:0] l_addr;
        logic [7:0] l_wdata;
        logic       l_wr;
        logic       l_rd;
        logic [7:0] rdata;
    } host_t;

    host_t s_q;
    host_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.l_wr = 1'b0;
        s_d.l_rd = 1'b0;
        s_d.rdata = 8'h00;

        // Device answer is caught the cycle after the link read
        s_d.pending = s_q.l_rd;

        if (i_wr) begin
            unique case (i_addr)
                led_cfg_pkg::H_TARGET: s_d.target = i_wdata;
                led_cfg_pkg::H_WRITE: begin
                    // Select bits must be cleared to override measured codes
                    s_d.l_addr  = s_q.target;                       // [RL5] [RL13]
                    s_d.l_wdata = i_wdata;
                    s_d.l_wr    = 1'b1;
                end
                led_cfg_pkg::H_READ: begin
                    s_d.l_addr = s_q.target;
                    s_d.l_rd   = 1'b1;
                    s_d.done   = 1'b0;
                end
                default: s_d.target = s_q.target;
            endcase
        end

        // A finishing read wins over the clear of a new command
        if (s_q.pending) begin
            s_d.result = link.rdata;
            s_d.done   = 1'b1;
        end

        if (i_rd) begin
            unique case (i_addr)
                led_cfg_pkg::H_TARGET: s_d.rdata = s_q.target;
                led_cfg_pkg::H_RESULT: s_d.rdata = s_q.result;
                led_cfg_pkg::H_STATUS: s_d.rdata = {7'h00, s_q.done};
                default:               s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata    = s_q.rdata;
    assign link.addr  = s_q.l_addr;
    assign link.wdata = s_q.l_wdata;
    assign link.wr    = s_q.l_wr;
    assign link.rd    = s_q.l_rd;

endmodule
`default_nettype wire

//--- tb/led_cfg_checker.sv
// Assertions on the register link between the host controller and the device.
// Assumes both ends share i_clk and the asynchronous i_rst_n.
`timescale 1ns/1ns
`default_nettype none
module led_cfg_checker (
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    // Link signals
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // Last byte written per register; a cleared select bit can never be set again
    logic [7:0] w11_q;
    logic [7:0] w12_q;
    logic [7:0] w13_q;
    logic       clr11_q;
    logic       clr12_q;
    logic       v13_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            w11_q   <= 8'h00;
            w12_q   <= 8'h00;
            w13_q   <= 8'h00;
            clr11_q <= 1'b0;
            clr12_q <= 1'b0;
            v13_q   <= 1'b0;
        end else if (wr && addr == 8'h11) begin
            w11_q   <= wdata;
            clr11_q <= clr11_q | ~wdata[7];
        end else if (wr && addr == 8'h12) begin
            w12_q   <= wdata;
            clr12_q <= clr12_q | ~wdata[7];
        end else if (wr && addr == 8'h13) begin
            w13_q <= wdata;
            v13_q <= 1'b1;
        end
    end

    sequence rd_of(a);
        rd && addr == a;
    endsequence

    rw_excl_a: assert property (!(wr && rd))
        else $error("link write and read strobes overlap");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside the read answer");
    unmapped_rd_a: assert property (rd && (addr < 8'h11 || addr > 8'h13) |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    cur_rsvd_a: assert property (rd_of(8'h11) |=> rdata[6:3] == 4'h0)
        else $error("current register reserved bits not zero");
    pwm_rsvd_a: assert property (rd_of(8'h12) |=> !rdata[6])
        else $error("pwm register reserved bit not zero");
    cur_code_a: assert property (rd_of(8'h11) ##0 clr11_q |=> rdata == {5'h00, w11_q[2:0]})
        else $error("current readback differs from stored code");
    pwm_code_a: assert property (rd_of(8'h12) ##0 clr12_q |=> rdata == {2'h0, w12_q[5:0]})
        else $error("pwm readback differs from stored code");
    boost_rb_a: assert property (rd_of(8'h13) ##0 v13_q |=> rdata == w13_q)
        else $error("boost readback differs from last write");
endmodule
`default_nettype wire

//--- tb/led_driver_config_registers_tb.sv
// Bench for the LED driver register bank driven through its host controller.
// Assumes one 100 MHz clock for both ends; terminals are driven as steady levels.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module led_driver_config_registers_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] e;
        logic [9:0] o;
    } row_t;
    localparam logic [5:0] MA_TBL [8] = '{6'h05, 6'h0A, 6'h0F, 6'h14, 6'h17, 6'h19, 6'h1E, 6'h32};

    logic        i_clk;
    logic        i_rst_n;
    logic [2:0]  sw_addr;
    logic [7:0]  sw_wdata;
    logic        sw_wr;
    logic        sw_rd;
    logic [7:0]  sw_rdata;
    logic [7:0]  nv_cur;
    logic [7:0]  nv_pwm;
    logic [7:0]  nv_bst;
    logic [2:0]  cur_code;
    logic        cur_flt;
    logic [2:0]  frq_code;
    logic        frq_flt;
    logic [11:0] brt;
    logic        ready;
    logic [2:0]  fsc_code;
    logic [5:0]  fsc_ma;
    logic [2:0]  frq_out;
    logic [8:0]  frq_dk;
    logic        pwm_dim;
    logic [11:0] duty;
    logic        ind;
    logic        bsw;
    logic [7:0]  d;
    row_t        rows[$];
    int          num_errors = 0;
    int          cmp_count = 0;

    led_cfg_link link();
    led_cfg_regs u_led_cfg_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link),
        .i_nv_current(nv_cur), .i_nv_pwm(nv_pwm), .i_nv_boost(nv_bst),
        .i_current_set_terminal_code(cur_code), .i_current_set_terminal_fault(cur_flt),
        .i_freq_set_pin_code(frq_code), .i_freq_set_pin_fault(frq_flt), .i_brightness(brt),
        .o_ready(ready), .o_full_scale_current_code(fsc_code), .o_full_scale_current_ma(fsc_ma),
        .o_pwm_out_freq_code(frq_out), .o_pwm_out_freq_dkhz(frq_dk), .o_pwm_dimming(pwm_dim),
        .o_pwm_duty(duty), .o_inductor_size(ind), .o_boost_switch_freq(bsw));
    led_cfg_host u_led_cfg_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(sw_addr),
        .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd), .o_rdata(sw_rdata), .link(link));
    led_cfg_checker u_led_cfg_checker (.i_clk(i_clk), .i_rst_n(i_rst_n), .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic sw_wr_t(input logic [2:0] a, input logic [7:0] v);
        @(posedge i_clk);
        sw_addr  <= a;
        sw_wdata <= v;
        sw_wr    <= 1'b1;
        @(posedge i_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_rd_t(input logic [2:0] a, output logic [7:0] v);
        @(posedge i_clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge i_clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask

    // Settle time covers the host's one-cycle issue delay plus the register update
    task automatic link_wr(input logic [7:0] a, input logic [7:0] v);
        sw_wr_t(led_cfg_pkg::H_TARGET, a);
        sw_wr_t(led_cfg_pkg::H_WRITE, v);
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    task automatic link_rd(input logic [7:0] a, output logic [7:0] v);
        logic [7:0] s;
        sw_wr_t(led_cfg_pkg::H_TARGET, a);
        sw_wr_t(led_cfg_pkg::H_READ, 8'h00);
        s = 8'h00;
        for (int i = 0; i < 20 && s[0] !== 1'b1; i++) sw_rd_t(led_cfg_pkg::H_STATUS, s);
        if (s[0] !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        sw_rd_t(led_cfg_pkg::H_RESULT, v);
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (12) @(posedge i_clk);
        `CHK(ready, 1'b0)
        i_rst_n <= 1'b1;
        for (int i = 0; i < 400 && ready !== 1'b1; i++) @(posedge i_clk);
        if (ready !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        #1;
    endtask

    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    initial begin
        {i_rst_n, sw_addr, sw_wdata, sw_wr, sw_rd, cur_flt, frq_flt} = '0;
        nv_cur   = 8'h80;
        nv_pwm   = 8'hA8;
        nv_bst   = 8'h01;
        cur_code = 3'h6;
        frq_code = 3'h1;
        brt      = 12'h200;
        do_reset();
        // Select bits loaded at one: both settings come from the terminals
        `CHK(fsc_code, 3'h6)
        link_rd(8'h11, d);
        `CHK(d, 8'h86)
        `CHK(frq_out, 3'h1)
        @(posedge i_clk);
        cur_code <= 3'h2;
        frq_code <= 3'h7;
        settle();
        `CHK(frq_out, 3'h7)
        `CHK(fsc_code, 3'h6)
        link_rd(8'h12, d);
        `CHK(d, 8'hAF)
        @(posedge i_clk);
        frq_flt <= 1'b1;
        settle();
        `CHK(frq_out, 3'h3)
        @(posedge i_clk);
        frq_flt <= 1'b0;
        `CHK(duty, 12'h200)
        $display("Test terminal sources done");

        // Clearing the select bits hands both settings to the host
        link_wr(8'h11, 8'h00);
        link_wr(8'h12, 8'h00);
        for (int c = 0; c < 8; c++) rows.push_back({8'h11, 8'hF8 | 8'(c), 8'(c), {4'h0, MA_TBL[c]}});
        rows.push_back({8'h12, 8'hC0, 8'h00, 10'h031});
        rows.push_back({8'h12, 8'hE9, 8'h29, 10'h262});
        rows.push_back({8'h12, 8'hFB, 8'h3B, 10'h2C3});
        rows.push_back({8'h12, 8'hD7, 8'h17, 10'h187});
        rows.push_back({8'h13, 8'h02, 8'h02, 10'h003});
        rows.push_back({8'h13, 8'hFC, 8'hFC, 10'h002});
        rows.push_back({8'h14, 8'hFF, 8'h00, 10'h000});
        foreach (rows[i]) begin
            link_wr(rows[i].a, rows[i].w);
            link_rd(rows[i].a, d);
            `CHK(d, rows[i].e)
            case (rows[i].a)
                8'h11: `CHK({4'h0, fsc_ma}, rows[i].o)
                8'h12: `CHK({pwm_dim, frq_dk}, rows[i].o)
                8'h13: `CHK({8'h00, bsw, ind}, rows[i].o)
                default: ;
            endcase
        end
        sw_rd_t(3'h5, d);
        `CHK(d, 8'h00)
        sw_rd_t(led_cfg_pkg::H_TARGET, d);
        `CHK(d, 8'h14)
        sw_wr_t(led_cfg_pkg::H_RESULT, 8'h5A);
        sw_rd_t(led_cfg_pkg::H_RESULT, d);
        `CHK(d, 8'h00)
        $display("Test host register rows done");

        // Second reset with a faulty current-set terminal
        @(posedge i_clk);
        cur_flt <= 1'b1;
        cur_code <= 3'h6;
        do_reset();
        `CHK(fsc_code, 3'h4)
        `CHK(fsc_ma, 6'h17)
        link_rd(8'h11, d);
        `CHK(d, 8'h84)
        $display("Test terminal fault fallback done");
        give_verdict();
    end
endmodule
`default_nettype wire
